// >>> core/bpi_core.sv
`timescale 1ns/1ps
`include "bpi_defines.svh"

module bpi_core (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire bpi_pkg::bpi_req_t reg_req,
    output logic [15:0]           reg_rdata,
    input  wire logic [3:0]       limit_in,
    output logic [3:0]            pulse_plus,
    output logic [3:0]            pulse_minus,
    output logic                  driving,
    output logic                  continuous_interp_irq_n
);

    bpi_pkg::bpi_state_t state_reg;
    bpi_pkg::bpi_state_t state_next;

    logic [3:0]  slot_p;
    logic [3:0]  slot_m;
    logic [3:0]  main_onehot;
    logic [15:0] period_eff;

    // ----------------------------------------------------------------
    // Per-axis slot bits
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_axis
            // Same bit position for every axis in a slot
            assign slot_p[g] = state_reg.axes[g] &
                state_reg.stages[state_reg.rd_ptr].plus[g][state_reg.bit_idx];
            assign slot_m[g] = state_reg.axes[g] &
                state_reg.stages[state_reg.rd_ptr].minus[g][state_reg.bit_idx];
        end
    endgenerate

    // Lowest selected axis is the main axis
    assign main_onehot = state_reg.axes & (~state_reg.axes + 4'h1);

    // Periods faster than 4 MHz are clamped, not refused
    assign period_eff = (state_reg.period < 16'(`BPI_MIN_PERIOD)) ?
                        16'(`BPI_MIN_PERIOD) : state_reg.period;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [7:0] code;
        logic [3:0] ax;
        logic       inc;
        logic       dec;
        logic       flush;
        logic       next_flag;
        code      = reg_req.wdata[`BPI_CMD_CODE_MSB:0];
        ax        = reg_req.wdata[`BPI_CMD_AXIS_MSB:`BPI_CMD_AXIS_LSB];
        inc       = 1'b0;
        dec       = 1'b0;
        flush     = 1'b0;
        next_flag = state_reg.driving && (state_reg.count != 4'h0) &&
                    (state_reg.count != `BPI_STAGES);
        state_next         = state_reg;
        state_next.rdata   = 16'h0000;
        state_next.pulse_p = 4'h0;
        state_next.pulse_m = 4'h0;
        state_next.lim_s1  = limit_in;
        state_next.lim_s2  = state_reg.lim_s1;

        if (reg_req.rd)
        begin
            case (reg_req.addr)
                `BPI_ADDR_STATUS:
                begin
                    state_next.rdata[15:`BPI_ST_COUNT_LSB] = state_reg.count;
                    state_next.rdata[`BPI_ST_NEXT]         = next_flag;
                    state_next.rdata[`BPI_ST_DRIVING]      = state_reg.driving;
                    state_next.rdata[`BPI_ST_HOLD]         = state_reg.hold;
                end
                `BPI_ADDR_PERIOD: state_next.rdata = state_reg.period;
                `BPI_ADDR_CTRL:   state_next.rdata = {15'h0000, state_reg.irq_sel};
                default:          state_next.rdata = 16'h0000;
            endcase
        end

        if (reg_req.wr)
        begin
            case (reg_req.addr)
                `BPI_ADDR_PLUS:   state_next.plus_data  = reg_req.wdata;
                `BPI_ADDR_MINUS:  state_next.minus_data = reg_req.wdata;
                `BPI_ADDR_PERIOD: state_next.period     = reg_req.wdata;
                `BPI_ADDR_CTRL:   state_next.irq_sel    = reg_req.wdata[0];
                `BPI_ADDR_CMD:
                begin
                    case (code)
                        `BPI_CMD_MODE:
                            state_next.axes = state_reg.plus_data[3:0];
                        `BPI_CMD_LOAD:
                        begin
                            for (int i = 0; i < 4; i++)
                            begin
                                if (ax[i])
                                begin
                                    state_next.pend.plus[i]  = state_reg.plus_data;
                                    state_next.pend.minus[i] = state_reg.minus_data;
                                end
                            end
                        end
                        `BPI_CMD_BP2, `BPI_CMD_BP3, `BPI_CMD_BP4:
                        begin
                            // A full pre-buffer silently drops the commit
                            if (state_reg.count != `BPI_STAGES)
                            begin
                                state_next.stages[state_reg.wr_ptr] = state_reg.pend;
                                state_next.wr_ptr = state_reg.wr_ptr + 3'h1;
                                inc               = 1'b1;
                                state_next.irq_n  = 1'b1;
                                if (!state_reg.hold)
                                begin
                                    state_next.driving = 1'b1;
                                end
                            end
                        end
                        `BPI_CMD_HOLD:
                        begin
                            if ((ax & main_onehot) != 4'h0)
                            begin
                                state_next.hold = 1'b1;
                            end
                        end
                        `BPI_CMD_RELEASE:
                        begin
                            if ((ax & main_onehot) != 4'h0)
                            begin
                                state_next.hold = 1'b0;
                                if (state_reg.count != 4'h0)
                                begin
                                    state_next.driving = 1'b1;
                                end
                            end
                        end
                        `BPI_CMD_DEC_STOP, `BPI_CMD_INST_STOP:
                        begin
                            if ((ax & main_onehot) != 4'h0)
                            begin
                                flush = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end

        // ----------------------------------------------------------------
        // Pulse engine
        // ----------------------------------------------------------------
        if (state_reg.driving)
        begin
            if (state_reg.lim_s2 != 4'h0)
            begin
                flush = 1'b1;
            end
            else if (state_reg.timer == 16'h0000)
            begin
                state_next.timer = period_eff - 16'h0001;
                if ((slot_p & slot_m) != 4'h0)
                begin
                    flush = 1'b1;
                end
                else
                begin
                    state_next.pulse_p = slot_p;
                    state_next.pulse_m = slot_m;
                    if (state_reg.bit_idx == `BPI_LAST_BIT)
                    begin
                        state_next.bit_idx = 4'h0;
                        state_next.rd_ptr  = state_reg.rd_ptr + 3'h1;
                        dec                = 1'b1;
                    end
                    else
                    begin
                        state_next.bit_idx = state_reg.bit_idx + 4'h1;
                    end
                end
            end
            else
            begin
                state_next.timer = state_reg.timer - 16'h0001;
            end
        end

        // ----------------------------------------------------------------
        // Stack counter and interrupt
        // ----------------------------------------------------------------
        if (flush)
        begin
            state_next.count   = 4'h0;
            state_next.wr_ptr  = 3'h0;
            state_next.rd_ptr  = 3'h0;
            state_next.bit_idx = 4'h0;
            state_next.timer   = 16'h0000;
            state_next.driving = 1'b0;
            state_next.pulse_p = 4'h0;
            state_next.pulse_m = 4'h0;
            state_next.irq_n   = 1'b1;
        end
        else
        begin
            state_next.count = state_reg.count + {3'h0, inc} - {3'h0, dec};
            if (dec && !inc)
            begin
                if (state_reg.count == 4'h1)
                begin
                    // Buffer drained: finish after the last stage
                    state_next.driving = 1'b0;
                    state_next.timer   = 16'h0000;
                    state_next.irq_n   = 1'b1;
                end
                // A same-cycle commit clear wins over the falling event
                else if ((!state_reg.irq_sel && state_reg.count == `BPI_IRQ_HI_FROM) ||
                         (state_reg.irq_sel && state_reg.count == `BPI_IRQ_LO_FROM))
                begin
                    state_next.irq_n = 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state_reg        <= '0;
            state_reg.period <= `BPI_PERIOD_RST;
            state_reg.irq_n  <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata               = state_reg.rdata;
    assign pulse_plus              = state_reg.pulse_p;
    assign pulse_minus             = state_reg.pulse_m;
    assign driving                 = state_reg.driving;
    assign continuous_interp_irq_n = state_reg.irq_n;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    logic cmd_wr;
    assign cmd_wr = reg_req.wr && (reg_req.addr == `BPI_ADDR_CMD);

    AST_COUNT_MAX: assert property (state_reg.count <= `BPI_STAGES)
        else $error("stack counter above eight");

    AST_NEXT_FLAG: assert property (reg_req.rd && reg_req.addr == `BPI_ADDR_STATUS
        |=> reg_rdata[`BPI_ST_NEXT] == ($past(state_reg.driving) &&
            $past(state_reg.count) >= 4'h1 && $past(state_reg.count) <= 4'h7))
        else $error("next-data flag wrong");

    AST_COMMIT_INC: assert property (cmd_wr && reg_req.wdata[7:0] == `BPI_CMD_BP2 &&
        !state_reg.driving && state_reg.count < `BPI_STAGES
        |=> state_reg.count == $past(state_reg.count) + 4'h1 &&
            state_reg.driving == !$past(state_reg.hold))
        else $error("commit did not count up or start");

    AST_FULL_REFUSE: assert property (cmd_wr && state_reg.count == `BPI_STAGES &&
        reg_req.wdata[7:0] inside {`BPI_CMD_BP2, `BPI_CMD_BP3, `BPI_CMD_BP4}
        |=> state_reg.count <= `BPI_STAGES)
        else $error("commit accepted while full");

    AST_STOP_FLUSH: assert property (cmd_wr && reg_req.wdata[7:0] == `BPI_CMD_INST_STOP &&
        (reg_req.wdata[11:8] & main_onehot) != 4'h0 |=> state_reg.count == 4'h0 && !driving)
        else $error("stop did not flush");

    AST_LIMIT_HALT: assert property (state_reg.driving && state_reg.lim_s2 != 4'h0
        |=> !driving ##1 pulse_plus == 4'h0 && pulse_minus == 4'h0)
        else $error("limit did not halt");

    AST_NO_BOTH: assert property ((pulse_plus & pulse_minus) == 4'h0)
        else $error("plus and minus pulse together");

    AST_PULSE_CAUSE: assert property ((pulse_plus | pulse_minus) != 4'h0
        |-> $past(state_reg.driving) && $past(state_reg.timer) == 16'h0000)
        else $error("pulse outside a slot");

    AST_SLOT_GAP: assert property ((pulse_plus | pulse_minus) != 4'h0
        |=> (pulse_plus | pulse_minus) == 4'h0 [*6])
        else $error("slots closer than minimum period");

    AST_IRQ_FINISH: assert property ($fell(driving) |-> continuous_interp_irq_n)
        else $error("interrupt held after finish");

    AST_IRQ_SET: assert property ((state_reg.driving && !state_reg.irq_sel &&
        state_reg.count == 4'h8) ##1 (state_reg.count == 4'h7)
        |-> !continuous_interp_irq_n)
        else $error("interrupt missing on 8 to 7");

    AST_IRQ_SET_LO: assert property ((state_reg.driving && state_reg.irq_sel &&
        state_reg.count == 4'h4) ##1 (state_reg.count == 4'h3)
        |-> !continuous_interp_irq_n)
        else $error("interrupt missing on 4 to 3");

    AST_IRQ_CLEAR: assert property (cmd_wr && state_reg.count != `BPI_STAGES &&
        reg_req.wdata[7:0] inside {`BPI_CMD_BP2, `BPI_CMD_BP3, `BPI_CMD_BP4}
        |=> continuous_interp_irq_n)
        else $error("interrupt held after commit");

    AST_HOLD_DEFER: assert property (cmd_wr && reg_req.wdata[7:0] == `BPI_CMD_HOLD &&
        (reg_req.wdata[11:8] & main_onehot) != 4'h0 && !state_reg.driving
        |=> state_reg.hold && !driving)
        else $error("hold did not defer driving");

    AST_RELEASE_GO: assert property (cmd_wr && reg_req.wdata[7:0] == `BPI_CMD_RELEASE &&
        (reg_req.wdata[11:8] & main_onehot) != 4'h0 && state_reg.count != 4'h0 &&
        !state_reg.driving |=> !state_reg.hold && driving)
        else $error("release did not start driving");

    AST_MODE_AXES: assert property (cmd_wr && reg_req.wdata[7:0] == `BPI_CMD_MODE
        |=> state_reg.axes == $past(state_reg.plus_data[3:0]))
        else $error("axis selection not taken");

    AST_LOAD_PEND: assert property (cmd_wr && reg_req.wdata[7:0] == `BPI_CMD_LOAD &&
        reg_req.wdata[`BPI_CMD_AXIS_LSB]
        |=> state_reg.pend.plus[0] == $past(state_reg.plus_data) &&
            state_reg.pend.minus[0] == $past(state_reg.minus_data))
        else $error("pattern not loaded into pending stage");

    AST_BIT_STEP: assert property (state_reg.driving && state_reg.timer == 16'h0000 &&
        state_reg.lim_s2 == 4'h0 && (slot_p & slot_m) == 4'h0 && !cmd_wr &&
        state_reg.bit_idx != `BPI_LAST_BIT
        |=> state_reg.bit_idx == $past(state_reg.bit_idx) + 4'h1)
        else $error("bit position did not advance by one");

    AST_COUNT_DEC: assert property (state_reg.driving &&
        state_reg.count == $past(state_reg.count) - 4'h1
        |-> $past(state_reg.bit_idx) == `BPI_LAST_BIT)
        else $error("stage retired before sixteen bits");

    AST_IDLE_EMPTY: assert property (state_reg.count == 4'h0 |-> !state_reg.driving)
        else $error("driving with an empty pre-buffer");

    COV_DRAIN: cover property ($fell(driving) && state_reg.count == 4'h0);
    COV_FULL:  cover property (state_reg.count == `BPI_STAGES);
    COV_IRQ:   cover property ($fell(continuous_interp_irq_n));
    COV_HOLD:  cover property (state_reg.hold && state_reg.count == 4'h3);
    COV_IRQ_LO: cover property (state_reg.irq_sel && $fell(continuous_interp_irq_n));

endmodule : bpi_core

// >>> core/bpi_defines.svh
`ifndef BPI_DEFINES_SVH
`define BPI_DEFINES_SVH

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define BPI_ADDR_CMD        3'h0
`define BPI_ADDR_PLUS       3'h1
`define BPI_ADDR_MINUS      3'h2
`define BPI_ADDR_STATUS     3'h3
`define BPI_ADDR_PERIOD     3'h4
`define BPI_ADDR_CTRL       3'h5

// ----------------------------------------------------------------
// Command codes and fields
// ----------------------------------------------------------------
`define BPI_CMD_MODE        8'h2A
`define BPI_CMD_LOAD        8'h06
`define BPI_CMD_BP2         8'h66
`define BPI_CMD_BP3         8'h67
`define BPI_CMD_BP4         8'h68
`define BPI_CMD_HOLD        8'h77
`define BPI_CMD_RELEASE     8'h78
`define BPI_CMD_DEC_STOP    8'h26
`define BPI_CMD_INST_STOP   8'h27
`define BPI_CMD_CODE_MSB    7
`define BPI_CMD_AXIS_LSB    8
`define BPI_CMD_AXIS_MSB    11

// ----------------------------------------------------------------
// Status fields and sizes
// ----------------------------------------------------------------
`define BPI_ST_DRIVING      0
`define BPI_ST_HOLD         1
`define BPI_ST_NEXT         11
`define BPI_ST_COUNT_LSB    12
`define BPI_STAGES          4'h8
`define BPI_IRQ_HI_FROM     4'h8
`define BPI_IRQ_LO_FROM     4'h4
`define BPI_LAST_BIT        4'hF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BPI_CLK_HZ          25000000
`define BPI_MAX_PPS         4000000
`define BPI_MIN_PERIOD      ((`BPI_CLK_HZ + `BPI_MAX_PPS - 1) / `BPI_MAX_PPS)
`define BPI_PERIOD_RST      16'h0019

`endif

// >>> core/bpi_pkg.sv
package bpi_pkg;

    typedef logic [15:0] bpi_word_t;

    typedef struct packed {
        logic [2:0] addr;
        bpi_word_t  wdata;
        logic       wr;
        logic       rd;
    } bpi_req_t;

    typedef struct packed {
        bpi_word_t [3:0] plus;
        bpi_word_t [3:0] minus;
    } bpi_stage_t;

    typedef struct packed {
        bpi_stage_t [7:0] stages;
        bpi_stage_t       pend;
        bpi_word_t        plus_data;
        bpi_word_t        minus_data;
        bpi_word_t        period;
        bpi_word_t        timer;
        bpi_word_t        rdata;
        logic [3:0]       axes;
        logic [3:0]       count;
        logic [3:0]       bit_idx;
        logic [2:0]       wr_ptr;
        logic [2:0]       rd_ptr;
        logic             driving;
        logic             hold;
        logic             irq_sel;
        logic             irq_n;
        logic [3:0]       pulse_p;
        logic [3:0]       pulse_m;
        logic [3:0]       lim_s1;
        logic [3:0]       lim_s2;
    } bpi_state_t;

endpackage : bpi_pkg

// >>> sim/bpi_host_model.sv
`timescale 1ns/1ps
`include "bpi_defines.svh"

// ----------------------------------------------------------------
// Host CPU on the register port
// ----------------------------------------------------------------
module bpi_host_model (
    input  wire logic         clk_sys,
    output bpi_pkg::bpi_req_t reg_req
);
    // Idle lines carry the inverse of the last value, so stale data never looks valid
    initial reg_req = '0;

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: reg_req.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req <= '{addr: ~a, wdata: ~reg_req.wdata, wr: 1'b0, rd: 1'b0};
    endtask : rd

    // Only masks with two to four axes are ever sent
    task automatic set_mode(input logic [3:0] axes);
        wr(`BPI_ADDR_PLUS, {12'h000, axes});
        wr(`BPI_ADDR_CMD, {8'h00, `BPI_CMD_MODE});
    endtask : set_mode

    // Every selected axis is loaded before the commit; with a 7-cycle slot a stage
    // lasts 112 cycles, well above the refill time of this sequence
    task automatic stage(input logic [3:0] axes, input logic [7:0] code,
                         input logic [15:0] p [4], input logic [15:0] m [4]);
        for (int a = 0; a < 4; a++)
            if (axes[a])
            begin
                wr(`BPI_ADDR_PLUS, p[a]);
                wr(`BPI_ADDR_MINUS, m[a]);
                wr(`BPI_ADDR_CMD, {4'h0, 4'(1 << a), `BPI_CMD_LOAD});
            end
        wr(`BPI_ADDR_CMD, {8'h00, code});
    endtask : stage
endmodule : bpi_host_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`include "bpi_defines.svh"

`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module tb_top;
    logic              clk_sys;
    logic              rst_b;
    bpi_pkg::bpi_req_t reg_req;
    logic [15:0]       reg_rdata;
    logic [3:0]        limit_in;
    logic [3:0]        pulse_plus;
    logic [3:0]        pulse_minus;
    logic              driving;
    logic              irq_n;
    logic              rd_d;
    logic [7:0]        exp_pulse [$];
    logic [15:0]       exp_rd [$];
    logic [7:0]        want_pulse;
    logic [15:0]       want_rd;
    integer            seed;
    int                n_mismatch;
    int                check_count;
    int                cycles;
    int                k;

    bpi_core bpi_core_inst (
        .clk_sys                 (clk_sys),
        .rst_b                   (rst_b),
        .reg_req                 (reg_req),
        .reg_rdata               (reg_rdata),
        .limit_in                (limit_in),
        .pulse_plus              (pulse_plus),
        .pulse_minus             (pulse_minus),
        .driving                 (driving),
        .continuous_interp_irq_n (irq_n)
    );

    bpi_host_model bpi_host_model_inst (
        .clk_sys (clk_sys),
        .reg_req (reg_req)
    );

    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // Result watcher
    // ----------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        rd_d   <= reg_req.rd;
        if (rd_d === 1'b1)
        begin
            want_rd = exp_rd.pop_front();
            `CHK(reg_rdata, want_rd)
        end
        if ((pulse_plus | pulse_minus) !== 4'h0)
        begin
            want_pulse = exp_pulse.pop_front();
            `CHK({pulse_plus, pulse_minus}, want_pulse)
        end
        if (cycles == 6000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic rd_chk(input logic [2:0] a, input logic [15:0] v);
        exp_rd.push_back(v);
        bpi_host_model_inst.rd(a);
    endtask : rd_chk

    // Random patterns, minus is the complement so every slot pulses;
    // stop_at puts an end code on the lowest axis
    task automatic fill_stage(input logic [3:0] axes, input logic [7:0] code,
                              input int stop_at, input bit keep);
        logic [15:0] p [4];
        logic [15:0] m [4];
        int          low;
        low = 0;
        for (int a = 3; a >= 0; a--)
            if (axes[a])
                low = a;
        for (int a = 0; a < 4; a++)
        begin
            p[a] = axes[a] ? 16'($random(seed)) : 16'h0000;
            m[a] = axes[a] ? ~p[a] : 16'h0000;
            if (a == low && stop_at >= 0)
            begin
                p[a][stop_at] = 1'b1;
                m[a][stop_at] = 1'b1;
            end
        end
        for (int i = 0; keep && i < 16 && (stop_at < 0 || i < stop_at); i++)
            exp_pulse.push_back({p[3][i], p[2][i], p[1][i], p[0][i],
                                 m[3][i], m[2][i], m[1][i], m[0][i]});
        bpi_host_model_inst.stage(axes, code, p, m);
    endtask : fill_stage

    task automatic wait_idle();
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 2000 && driving !== 1'b0; i++)
            @(posedge clk_sys);
        `CHK(driving, 1'b0)
        // One more edge so the watcher has taken the last slot off the queue
        @(posedge clk_sys);
        `CHK(exp_pulse.size(), 0)
    endtask : wait_idle

    // Sampled mid-cycle, where a one-cycle pulse is settled
    task automatic wait_pulse();
        for (int i = 0; i < 50 && (pulse_plus | pulse_minus) === 4'h0; i++)
            @(negedge clk_sys);
    endtask : wait_pulse

    task automatic stop_mid(input logic [7:0] code);
        wait_pulse();
        bpi_host_model_inst.wr(`BPI_ADDR_CMD, {8'h01, code});
        exp_pulse.delete();
        rd_chk(`BPI_ADDR_STATUS, 16'h0000);
        `CHK(driving, 1'b0)
    endtask : stop_mid

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed        = 32'hE11D6113;
        rst_b       = 1'b0;
        limit_in    = 4'h0;
        n_mismatch  = 0;
        check_count = 0;
        cycles      = 0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd_chk(`BPI_ADDR_STATUS, 16'h0000);
        rd_chk(`BPI_ADDR_PERIOD, `BPI_PERIOD_RST);
        rd_chk(3'h6, 16'h0000);
        bpi_host_model_inst.wr(`BPI_ADDR_PERIOD, 16'h0007);
        rd_chk(`BPI_ADDR_PERIOD, 16'h0007);
        for (k = 0; k < 3; k++)
        begin
            bpi_host_model_inst.set_mode(4'(4'hF >> (2 - k)));
            fill_stage(4'(4'hF >> (2 - k)), 8'(`BPI_CMD_BP2 + k), -1, 1'b1);
            wait_idle();
            rd_chk(`BPI_ADDR_STATUS, 16'h0000);
        end
        bpi_host_model_inst.set_mode(4'h3);
        bpi_host_model_inst.wr(`BPI_ADDR_CMD, {8'h01, `BPI_CMD_HOLD});
        for (k = 0; k < 9; k++)
            fill_stage(4'h3, `BPI_CMD_BP2, -1, k < 8);
        rd_chk(`BPI_ADDR_STATUS, 16'h8002);
        bpi_host_model_inst.wr(`BPI_ADDR_CMD, {8'h01, `BPI_CMD_RELEASE});
        for (k = 0; k < 400 && irq_n !== 1'b0; k++)
            @(posedge clk_sys);
        `CHK(irq_n, 1'b0)
        rd_chk(`BPI_ADDR_STATUS, 16'h7801);
        fill_stage(4'h3, `BPI_CMD_BP2, -1, 1'b1);
        repeat (2) @(posedge clk_sys);
        `CHK(irq_n, 1'b1)
        stop_mid(`BPI_CMD_INST_STOP);
        fill_stage(4'h3, `BPI_CMD_BP2, -1, 1'b1);
        stop_mid(`BPI_CMD_DEC_STOP);
        fill_stage(4'h3, `BPI_CMD_BP2, 5, 1'b1);
        fill_stage(4'h3, `BPI_CMD_BP2, -1, 1'b0);
        wait_idle();
        rd_chk(`BPI_ADDR_STATUS, 16'h0000);
        fill_stage(4'h3, `BPI_CMD_BP2, -1, 1'b1);
        wait_pulse();
        @(posedge clk_sys);
        limit_in <= 4'h2;
        repeat (4) @(posedge clk_sys);
        exp_pulse.delete();
        `CHK(driving, 1'b0)
        rd_chk(`BPI_ADDR_STATUS, 16'h0000);
        limit_in <= 4'h0;
        repeat (20) @(posedge clk_sys);
        `CHK(exp_pulse.size(), 0)
        // Too short a period must be clamped; the slot gap assertion watches it
        bpi_host_model_inst.wr(`BPI_ADDR_PERIOD, 16'h0002);
        bpi_host_model_inst.wr(`BPI_ADDR_CTRL, 16'h0001);
        rd_chk(`BPI_ADDR_CTRL, 16'h0001);
        bpi_host_model_inst.wr(`BPI_ADDR_CMD, {8'h01, `BPI_CMD_HOLD});
        for (k = 0; k < 4; k++)
            fill_stage(4'h3, `BPI_CMD_BP2, -1, 1'b1);
        bpi_host_model_inst.wr(`BPI_ADDR_CMD, {8'h01, `BPI_CMD_RELEASE});
        for (k = 0; k < 400 && irq_n !== 1'b0; k++)
            @(posedge clk_sys);
        `CHK(irq_n, 1'b0)
        rd_chk(`BPI_ADDR_STATUS, 16'h3801);
        wait_idle();
        `CHK(irq_n, 1'b1)
        report_and_stop();
    end
endmodule : tb_top
